// [rtl/pos_pkg.sv]
package pos_pkg;
   // ----------------------------------------
   // count source selection
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      POS_SRC_F1,
      POS_SRC_F2,
      POS_SRC_F8,
      POS_SRC_COMP
   } pos_src_e;

   localparam int POS_DIV2 = 2;
   localparam int POS_DIV8 = 8;
   localparam logic [7:0] POS_RST_VAL = 8'hFF;
   localparam logic [7:0] POS_ZERO = 8'h00;

   // ----------------------------------------
   // software write strobes
   // ----------------------------------------
   typedef struct packed
   {
      logic run_set;
      logic run_clr;
      logic forced_halt;
      logic launch;
      logic abort;
   } pos_ctl_s;

   // ----------------------------------------
   // pin trigger configuration
   // ----------------------------------------
   typedef struct packed
   {
      logic pin_trigger_enable;
      logic both_edge_select;
      logic trigger_edge_select;
      logic irq_edge_polarity;
      logic pin_input_enable_n;
   } pos_pin_cfg_s;
endpackage

// [rtl/pos_timer.sv]
`timescale 1ns/10ps
// How it works
// - prescaler clocked by f1, f2, f8 or companion
// - reload register and down-counter for each stage
// - primary decrements per prescaler underflow only
// - primary underflow reloads, ends, clears active flag
// - any stop reloads counters before halting
// - pulse lasts (n+1)(m+1) source periods
// - start needs run request then a trigger
// - trigger from launch write or pin edge
// - abort, run clear or forced halt stop counting
// - interrupt half source cycle after underflow
// - pin triggers only when pin-trigger enable set
// - count reads return live counter values
// - writes while stopped load reload and counter
// - writes while counting load reload only
// - level select sets pulse polarity
// - trigger honoured only while count status set
// - active flag set one clk after second source tick after trigger pends
// - triggers during active pulse are ignored
// - edge select picks rising or falling edge
// - edge select never alters pin irq polarity
// - ignored pin trigger still raises pin irq
module pos_timer
#(
   parameter int CNT_W = 8
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire pos_pkg::pos_src_e i_src_sel,
   input wire logic i_comp_underflow,
   input wire pos_pkg::pos_ctl_s i_ctl,
   input wire logic i_prescale_wr,
   input wire logic i_primary_wr,
   input wire logic [CNT_W-1:0] i_wdata,
   input wire logic i_output_level_select,
   input wire pos_pkg::pos_pin_cfg_s i_pin_cfg,
   input wire logic i_ext_trigger_pin,
   input wire logic i_irq_request_clr,
   output logic [CNT_W-1:0] o_prescale_count_reg,
   output logic [CNT_W-1:0] o_primary_count_reg,
   output logic o_count_status_flag,
   output logic o_oneshot_active_flag,
   output logic o_pulse_out_pin,
   output logic o_timer_irq,
   output logic o_irq_request_flag,
   output logic o_pin_level
);
   import pos_pkg::*;

   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   // reload and zero constants are fixed at eight bits
   if (CNT_W != $bits(POS_RST_VAL))
   begin : g_width_chk
      $error("counter width must match package constants");
   end

   // ----------------------------------------
   // count source
   // ----------------------------------------
   logic [2:0] div_reg;
   logic tick;
   logic tick_half;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         div_reg <= '0;
      else
         div_reg <= div_reg + 3'h1;
   end

   always_comb
   begin
      case (i_src_sel)
         POS_SRC_F1: tick = 1'b1;
         POS_SRC_F2: tick = (div_reg[0] == 1'b1);
         POS_SRC_F8: tick = (div_reg == 3'(POS_DIV8 - 1));
         POS_SRC_COMP: tick = i_comp_underflow;
         default: tick = 1'b0;
      endcase
   end

   // ----------------------------------------
   // pin synchroniser and edge detect
   // ----------------------------------------
   logic pin_s1_reg;
   logic pin_s2_reg;
   logic pin_d_reg;
   logic rise;
   logic fall;
   logic pin_edge;
   logic irq_edge;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pin_s1_reg <= 1'b1;
         pin_s2_reg <= 1'b1;
         pin_d_reg <= 1'b1;
      end
      else
      begin
         pin_s1_reg <= i_ext_trigger_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_d_reg <= pin_s2_reg;
      end
   end

   assign rise = pin_s2_reg & ~pin_d_reg;
   assign fall = ~pin_s2_reg & pin_d_reg;
   assign o_pin_level = pin_d_reg;
   assign pin_edge = ~i_pin_cfg.pin_input_enable_n & (i_pin_cfg.both_edge_select ?
      (rise | fall) : (i_pin_cfg.trigger_edge_select ? rise : fall));
   assign irq_edge = ~i_pin_cfg.pin_input_enable_n & (i_pin_cfg.both_edge_select ?
      (rise | fall) : (i_pin_cfg.irq_edge_polarity ? rise : fall));

   // pin irq flag, set wins over clear
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_irq_request_flag <= 1'b0;
      else if (irq_edge)
         o_irq_request_flag <= 1'b1;
      else if (i_irq_request_clr)
         o_irq_request_flag <= 1'b0;
   end

   // ----------------------------------------
   // run control
   // ----------------------------------------
   logic stop_req;
   logic trig_now;
   logic trig_pend_reg;
   logic pend_age_reg;
   logic start;

   assign stop_req = i_ctl.abort | i_ctl.run_clr | i_ctl.forced_halt;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_count_status_flag <= 1'b0;
      else if (i_ctl.run_clr | i_ctl.forced_halt)
         o_count_status_flag <= 1'b0;
      else if (i_ctl.run_set)
         o_count_status_flag <= 1'b1;
   end

   assign trig_now = i_ctl.launch | (i_pin_cfg.pin_trigger_enable & pin_edge);

   // pending trigger aligned to count source
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         trig_pend_reg <= 1'b0;
      else if (stop_req | !o_count_status_flag | start)
         trig_pend_reg <= 1'b0;
      else if (trig_now & !o_oneshot_active_flag)
         trig_pend_reg <= 1'b1;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         pend_age_reg <= 1'b0;
      else if (!trig_pend_reg | start)
         pend_age_reg <= 1'b0;
      else if (tick)
         pend_age_reg <= 1'b1;
   end

   // starts on second source tick after trigger pends
   assign start = trig_pend_reg & pend_age_reg & tick & !stop_req;

   // ----------------------------------------
   // counters
   // ----------------------------------------
   logic [CNT_W-1:0] pre_rld_reg;
   logic [CNT_W-1:0] pri_rld_reg;
   logic pre_uf;
   logic pri_uf;

   assign pre_uf = o_oneshot_active_flag & tick & (o_prescale_count_reg == POS_ZERO);
   assign pri_uf = pre_uf & (o_primary_count_reg == POS_ZERO);

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pre_rld_reg <= POS_RST_VAL;
         pri_rld_reg <= POS_RST_VAL;
      end
      else
      begin
         if (i_prescale_wr)
            pre_rld_reg <= i_wdata;
         if (i_primary_wr)
            pri_rld_reg <= i_wdata;
      end
   end

   // prescaler counter
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_prescale_count_reg <= POS_RST_VAL;
      else if (i_prescale_wr & !o_oneshot_active_flag)
         o_prescale_count_reg <= i_wdata;
      else if (o_oneshot_active_flag & stop_req)
         o_prescale_count_reg <= pre_rld_reg;
      else if (pre_uf)
         o_prescale_count_reg <= pre_rld_reg;
      else if (o_oneshot_active_flag & tick)
         o_prescale_count_reg <= o_prescale_count_reg - 8'h01;
   end

   // primary counter
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_primary_count_reg <= POS_RST_VAL;
      else if (i_primary_wr & !o_oneshot_active_flag)
         o_primary_count_reg <= i_wdata;
      else if (o_oneshot_active_flag & stop_req)
         o_primary_count_reg <= pri_rld_reg;
      else if (pri_uf)
         o_primary_count_reg <= pri_rld_reg;
      else if (pre_uf)
         o_primary_count_reg <= o_primary_count_reg - 8'h01;
   end

   // active flag
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_oneshot_active_flag <= 1'b0;
      else if (stop_req | pri_uf)
         o_oneshot_active_flag <= 1'b0;
      else if (start)
         o_oneshot_active_flag <= 1'b1;
   end

   // ----------------------------------------
   // half-cycle end of pulse and interrupt
   // ----------------------------------------
   logic pulse_reg;
   logic end_pend_reg;
   logic irq_pre_reg;

   // half a source cycle: end at next tick midpoint, approximated by next clk for f1 and companion
   assign tick_half = (i_src_sel == POS_SRC_F1) ? 1'b1 :
      (i_src_sel == POS_SRC_F2) ? (div_reg[0] == 1'b0) :
      (i_src_sel == POS_SRC_F8) ? (div_reg == 3'(POS_DIV8 / POS_DIV2 - 1)) : 1'b1;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         end_pend_reg <= 1'b0;
      else if (pri_uf)
         end_pend_reg <= 1'b1;
      else if (tick_half | stop_req)
         end_pend_reg <= 1'b0;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         pulse_reg <= 1'b0;
      else if (start)
         pulse_reg <= 1'b1;
      else if (stop_req | (end_pend_reg & tick_half))
         pulse_reg <= 1'b0;
   end

   // irq waits one clk so it lines up with the registered pin
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         irq_pre_reg <= 1'b0;
      else
         irq_pre_reg <= end_pend_reg & tick_half & !stop_req;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_timer_irq <= 1'b0;
      else
         o_timer_irq <= irq_pre_reg;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_pulse_out_pin <= 1'b0;
      else
         o_pulse_out_pin <= pulse_reg ? i_output_level_select
            : ~i_output_level_select;
   end
endmodule

// [dv/pos_timer_assertions.sv]
`timescale 1ns/10ps
// ----
// checker
// ----
module pos_timer_checker
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire pos_pkg::pos_ctl_s i_ctl,
   input wire logic i_primary_wr,
   input wire logic i_output_level_select,
   input wire logic [7:0] o_primary_count_reg,
   input wire logic o_count_status_flag,
   input wire logic o_oneshot_active_flag,
   input wire logic o_pulse_out_pin,
   input wire logic o_timer_irq
);
   import pos_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   idle_level_a: assert property (
      (!o_oneshot_active_flag && $stable(i_output_level_select)) [*8]
      |-> o_pulse_out_pin == !i_output_level_select) else $error("idle level");
   active_level_a: assert property (
      $rose(o_oneshot_active_flag) |=> o_pulse_out_pin == i_output_level_select)
      else $error("pulse level");
   halt_stop_a: assert property (
      i_ctl.forced_halt || i_ctl.run_clr |-> ##[1:2] !o_count_status_flag)
      else $error("no stop");
   run_start_a: assert property (
      i_ctl.run_set && !i_ctl.run_clr && !i_ctl.forced_halt
      |-> ##[1:2] o_count_status_flag) else $error("no run");
   abort_stop_a: assert property (
      i_ctl.abort |-> ##[1:2] !o_oneshot_active_flag) else $error("no abort");
   stop_drop_a: assert property (
      $fell(o_count_status_flag) |-> ##[0:1] !o_oneshot_active_flag)
      else $error("active after stop");
   start_status_a: assert property (
      $rose(o_oneshot_active_flag) |-> $past(o_count_status_flag))
      else $error("start while stopped");
   irq_end_a: assert property (
      o_timer_irq |-> !o_oneshot_active_flag
      && o_pulse_out_pin != i_output_level_select) else $error("irq timing");
   count_hold_a: assert property (
      (!o_oneshot_active_flag && !i_primary_wr) [*8]
      |-> $stable(o_primary_count_reg)) else $error("count moved");
endmodule
bind pos_timer pos_timer_checker pos_timer_checker_inst (.*);

// [dv/pos_trig_src.sv]
`timescale 1ns/10ps
// ----
// trigger source
// ----
module pos_trig_src
(
   input wire logic i_clk,
   input wire logic i_fire,
   output logic o_pin
);
   logic [2:0] low_reg = 3'h0;
   // idle high, a fire gives a low pulse with both edges
   always @(posedge i_clk)
   begin
      if (i_fire)
         low_reg <= 3'h6;
      else if (low_reg != 3'h0)
         low_reg <= low_reg - 3'h1;
   end
   assign o_pin = (low_reg == 3'h0);
endmodule

// [dv/test_programmable_oneshot_timer.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
   $display("Error %0t: mismatch", $time); end end
module test_programmable_oneshot_timer;
   import pos_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   pos_src_e i_src_sel = POS_SRC_F1;
   logic i_comp_underflow = 1'b0;
   pos_ctl_s i_ctl = '0;
   logic i_prescale_wr = 1'b0;
   logic i_primary_wr = 1'b0;
   logic [7:0] i_wdata = 8'h00;
   logic i_output_level_select = 1'b1;
   pos_pin_cfg_s i_pin_cfg = '0;
   logic i_ext_trigger_pin, i_irq_request_clr = 1'b0, fire = 1'b0;
   logic [7:0] o_prescale_count_reg, o_primary_count_reg, rnd = 8'h49;
   logic o_count_status_flag, o_oneshot_active_flag, o_pulse_out_pin;
   logic o_timer_irq, o_irq_request_flag, o_pin_level;
   logic [4:0] stops [3] = '{5'h01, 5'h08, 5'h04};
   int cyc = 0, compares = 0, miscompares = 0;
   pos_timer pos_timer_inst (.*);
   pos_trig_src pos_trig_src_inst (.i_clk(i_clk), .i_fire(fire), .o_pin(i_ext_trigger_pin));
   always #10 i_clk = ~i_clk;
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      i_comp_underflow <= (cyc % 4 == 3);
      if (cyc == 40000)
      begin
         miscompares++;
         final_report();
      end
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic final_report();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic ctl(input logic [4:0] c);
      @(posedge i_clk);
      i_ctl <= pos_ctl_s'(c);
      @(posedge i_clk);
      i_ctl <= '0;
   endtask
   task automatic wr(input logic sel, input logic [7:0] d);
      @(posedge i_clk);
      i_wdata <= d;
      i_prescale_wr <= !sel;
      i_primary_wr <= sel;
      @(posedge i_clk);
      i_prescale_wr <= 1'b0;
      i_primary_wr <= 1'b0;
   endtask
   task automatic wait_act();
      for (int k = 0; k < 60 && o_oneshot_active_flag !== 1'b1; k++)
         @(negedge i_clk);
   endtask
   task automatic shot(input int s, input logic l);
      logic [7:0] n, m;
      int div, len;
      logic seen;
      rnd = lfsr(rnd);
      n = {6'h00, rnd[1:0]};
      m = {5'h00, rnd[4:2]} + 8'h04;
      div = (s == 0) ? 1 : (s == 1) ? 2 : (s == 2) ? 8 : 4;
      @(posedge i_clk);
      i_src_sel <= pos_src_e'(s);
      i_output_level_select <= l;
      ctl(5'h08);
      wr(1'b0, n);
      wr(1'b1, m);
      @(negedge i_clk);
      `CHK(o_prescale_count_reg, n)
      `CHK(o_primary_count_reg, m)
      ctl(5'h10);
      ctl(5'h02);
      wait_act();
      @(negedge i_clk);
      `CHK(o_pulse_out_pin, l)
      wr(1'b1, 8'h0F);
      @(negedge i_clk);
      `CHK(o_primary_count_reg !== 8'h0F, 1'b1)
      ctl(5'h02);
      @(negedge i_clk);
      len = 4;
      seen = 0;
      while (o_pulse_out_pin === l && len < 600)
      begin
         len++;
         @(negedge i_clk);
      end
      seen = o_timer_irq;
      div = len - (n + 1) * (m + 1) * div;
      `CHK(div >= -9 && div <= 9, 1'b1)
      `CHK(seen, 1'b1)
      repeat (20) @(negedge i_clk);
      `CHK(o_oneshot_active_flag, 1'b0)
      `CHK(o_primary_count_reg, 8'h0F)
   endtask
   initial
   begin
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(negedge i_clk);
      `CHK(o_primary_count_reg, POS_RST_VAL)
      ctl(5'h02);
      repeat (30) @(negedge i_clk);
      `CHK(o_oneshot_active_flag, 1'b0)
      for (int i = 0; i < 8; i++)
         shot(i % 4, i[2]);
      for (int i = 0; i < 3; i++)
      begin
         ctl(5'h10);
         ctl(5'h02);
         wait_act();
         ctl(stops[i]);
         repeat (3) @(negedge i_clk);
         `CHK(o_oneshot_active_flag, 1'b0)
         `CHK(o_primary_count_reg, 8'h0F)
         repeat (10) @(negedge i_clk);
         `CHK(o_pulse_out_pin, 1'b0)
      end
      ctl(5'h10);
      @(posedge i_clk);
      fire <= 1'b1;
      @(posedge i_clk);
      fire <= 1'b0;
      repeat (30) @(negedge i_clk);
      `CHK(o_oneshot_active_flag, 1'b0)
      `CHK(o_irq_request_flag, 1'b1)
      @(posedge i_clk);
      i_pin_cfg <= 5'h08;
      @(posedge i_clk);
      i_pin_cfg <= 5'h18;
      fire <= 1'b1;
      @(posedge i_clk);
      fire <= 1'b0;
      wait_act();
      `CHK(o_oneshot_active_flag, 1'b1)
      repeat (6) @(posedge i_clk);
      i_irq_request_clr <= 1'b1;
      @(posedge i_clk);
      i_irq_request_clr <= 1'b0;
      @(negedge i_clk);
      `CHK(o_irq_request_flag, 1'b0)
      @(posedge i_clk);
      fire <= 1'b1;
      @(posedge i_clk);
      fire <= 1'b0;
      repeat (15) @(negedge i_clk);
      `CHK(o_irq_request_flag, 1'b1)
      `CHK(o_oneshot_active_flag, 1'b1)
      final_report();
   end
endmodule
